// File: rsic_consts.vh
`ifndef RSIC_CONSTS_VH
`define RSIC_CONSTS_VH
`define RSIC_SP_OVF_A 3'h6
`define RSIC_SP_OVF_B 3'h7
`define RSIC_SP_EMPTY 3'h0
`define RSIC_SP_LEVEL_MAX 3'h6
`define RSIC_DBF_RESET 16'h0320
`define RSIC_TMC_RESET 8'h00
`define RSIC_TMM_RESET 8'hff
`define RSIC_WDT_RESET 8'h00
`define RSIC_CORE_SYSTEM_REGS_RESET 4'h0
`define RSIC_PORT_RESET 4'h0
`define RSIC_CLK_KHZ 50000
`define RSIC_LV_TIME_US 1000
`define RSIC_LV_CYCLES ((`RSIC_LV_TIME_US * `RSIC_CLK_KHZ) / 1000)
`define RSIC_WAIT_TIME_NS 16384000
`define RSIC_WAIT_CYCLES ((`RSIC_WAIT_TIME_NS + 19) / 20)
`endif

// File: rsic_core_model.sv
module rsic_core_model (
  input clk,
  input run_q,
  input do_call,
  input do_ret,
  input pin_oe_n,
  output pin_n,
  output reg [2:0] sp,
  output call,
  output ret
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulled-up pin, only the device pulls it low
  assign pin_n = pin_oe_n;
  assign call = do_call & run_q;
  assign ret = do_ret & run_q;
  // a restart puts the stack back at level five
  always @(posedge clk)
  begin
    if (!run_q)
      sp <= 3'h5;
    else
      sp <= sp - {2'b00, call} + {2'b00, ret};
  end
endmodule // rsic_core_model

// File: rsic_reset_chk.sv
module rsic_reset_chk (
  input clk,
  input rstn,
  input [2:0] sp_i,
  input sp_valid_i,
  input call_i,
  input standby_i,
  input regfile_write_op,
  input [3:0] window_wdata_i,
  input reset_pin_oe_n,
  input core_reset_q,
  input pc_clear_q,
  input run_q,
  input ram_retain_q,
  input [15:0] transfer_buffer_word,
  input regfile_we_q,
  input [3:0] regfile_wdata_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire live = run_q && sp_valid_i;
  a_stack_top: assert property (live && sp_i >= 3'h6 |=> !reset_pin_oe_n && core_reset_q)
    else $error("stack top");
  a_call_empty: assert property (live && call_i && sp_i == 3'h0 |=> core_reset_q)
    else $error("underflow");
  a_pc_follows: assert property (pc_clear_q == core_reset_q)
    else $error("pc clear");
  a_retain_cap: assert property ($rose(core_reset_q) |-> ram_retain_q == $past(standby_i))
    else $error("retain");
  a_buf_default: assert property (core_reset_q [*2] |-> transfer_buffer_word == 16'h0320)
    else $error("buffer");
  a_op_refused: assert property (!run_q && regfile_write_op |=> !regfile_we_q)
    else $error("op refused");
  a_op_write: assert property (run_q && regfile_write_op |=> regfile_we_q && regfile_wdata_q == $past(window_wdata_i))
    else $error("op write");
  a_run_gate: assert property (run_q |-> !core_reset_q)
    else $error("run gate");
  c_under: cover property (live && call_i && sp_i == 3'h0);
  c_top: cover property (live && sp_i == 3'h6);
  c_run: cover property ($rose(run_q));
endmodule // rsic_reset_chk

bind rsic_reset_ctrl rsic_reset_chk u_chk (.clk, .rstn, .sp_i, .sp_valid_i, .call_i, .standby_i, .regfile_write_op,
  .window_wdata_i, .reset_pin_oe_n, .core_reset_q, .pc_clear_q, .run_q, .ram_retain_q, .transfer_buffer_word,
  .regfile_we_q, .regfile_wdata_q);

// File: rsic_reset_ctrl.v
`include "rsic_consts.vh"
// Overview of operation
// - stack pointer 6 or 7 resets core
// - call or interrupt at sp zero resets; this design has no interrupt input, only call_i
// - return beyond level six resets
// - stack reset drives reset pin low
// - ram kept in standby, undefined otherwise
// - carrier modulos kept only in standby
// - low voltage flagged after 1 ms
// - shorter low voltage may still reset; this design never does
// - low voltage pulls pin low, initialises
// - detector fitted only by build option
// - carrier clock full or half rate
// - option pin direction fixed at build
// - register file via regfile_read_op regfile_write_op only
// - transfer buffer loads 0320 on reset
// - wait 16.384 ms before running
module rsic_reset_ctrl #(
  parameter LOW_VOLTAGE_OPTION = 1,
  parameter CARRIER_CLOCK_OPTION = 0,
  parameter OPTION_PIN_DIRECTION = 0,
  parameter PORT_W = 4,
  parameter LV_CYCLES = `RSIC_LV_CYCLES,
  parameter WAIT_CYCLES = `RSIC_WAIT_CYCLES
) (
  input wire clk,
  input wire rstn,
  input wire reset_pin_n_i,
  input wire low_vdd_i,
  input wire [2:0] sp_i,
  input wire sp_valid_i,
  input wire call_i,
  input wire ret_i,
  input wire standby_i,
  input wire regfile_read_op,
  input wire regfile_write_op,
  input wire [3:0] window_wdata_i,
  input wire [3:0] regfile_rdata_i,
  input wire option_pin_in_i,
  input wire option_pin_wdata_i,
  output reg reset_pin_o,
  output reg reset_pin_oe_n,
  output reg core_reset_q,
  output reg pc_clear_q,
  output reg run_q,
  output reg lv_flag_q,
  output reg ram_retain_q,
  output reg carrier_retain_q,
  output reg [15:0] transfer_buffer_word,
  output reg [3:0] core_system_regs,
  output reg [7:0] timer8_count,
  output reg [7:0] timer8_modulo,
  output reg [7:0] wdt_count_q,
  output reg [PORT_W-1:0] port_dir_out_q,
  output reg [PORT_W-1:0] port_latch_q,
  output reg carrier_clk_en_q,
  output reg option_pin_out_q,
  output reg option_pin_oe_n,
  output reg option_pin_rd_q,
  output reg regfile_we_q,
  output reg [3:0] regfile_wdata_q,
  output reg [3:0] window_rdata_q
);
  localparam ST_RESET = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;
  localparam [2:0] SYNC_IDLE = 3'b001;
  reg [2:0] state_q;
  reg [31:0] lv_cnt_q;
  reg [31:0] wait_cnt_q;
  reg half_q;
  wire [2:0] sync_in;
  wire [2:0] sync_out;
  wire pin_sync;
  wire lv_sync;
  wire opt_sync;
  wire sp_fault;
  wire lv_fault;
  wire any_reset;
  genvar gi;
  // pins cross into clk domain; each flop resets to its pin's idle level
  assign sync_in = {option_pin_in_i, low_vdd_i, reset_pin_n_i};
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1_q <= SYNC_IDLE[gi];
          s2_q <= SYNC_IDLE[gi];
        end
        else
        begin
          s1_q <= sync_in[gi];
          s2_q <= s1_q;
        end
      end
      assign sync_out[gi] = s2_q;
    end
  endgenerate
  assign pin_sync = sync_out[0];
  assign lv_sync = sync_out[1];
  assign opt_sync = sync_out[2];
  assign sp_fault = sp_valid_i & (state_q == ST_RUN) &
    ((sp_i == `RSIC_SP_OVF_A) | (sp_i == `RSIC_SP_OVF_B) |
     (call_i & (sp_i == `RSIC_SP_EMPTY)) |
     (ret_i & (sp_i >= `RSIC_SP_LEVEL_MAX)));
  // a short dip never resets; lv_fault rises only after the full LV_CYCLES count
  assign lv_fault = (LOW_VOLTAGE_OPTION != 0) && lv_flag_q;
  assign any_reset = !pin_sync | sp_fault | lv_fault;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lv_cnt_q <= 32'h0000_0000;
      lv_flag_q <= 1'b0;
    end
    // count stops at the limit; flag holds while the supply stays low
    else if (LOW_VOLTAGE_OPTION == 0 || !lv_sync)
    begin
      lv_cnt_q <= 32'h0000_0000;
      lv_flag_q <= 1'b0;
    end
    else if (lv_cnt_q >= LV_CYCLES - 1)
      lv_flag_q <= 1'b1;
    else
      lv_cnt_q <= lv_cnt_q + 32'h0000_0001;
  end
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_RESET;
      wait_cnt_q <= 32'h0000_0000;
      core_reset_q <= 1'b1;
      pc_clear_q <= 1'b1;
      run_q <= 1'b0;
    end
    else
    begin
      if (any_reset)
      begin
        state_q <= ST_RESET;
        core_reset_q <= 1'b1;
        pc_clear_q <= 1'b1;
        run_q <= 1'b0;
        wait_cnt_q <= 32'h0000_0000;
      end
      else
      begin
        case (state_q)
          ST_RESET:
          begin
            state_q <= ST_WAIT;
          end
          ST_WAIT:
          begin
            if (wait_cnt_q >= WAIT_CYCLES - 1)
            begin
              state_q <= ST_RUN;
              core_reset_q <= 1'b0;
              pc_clear_q <= 1'b0;
              run_q <= 1'b1;
            end
            else
              wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
          end
          ST_RUN:
          begin
            run_q <= 1'b1;
          end
          default:
          begin
            state_q <= ST_RESET;
          end
        endcase
      end
    end
  end
  // pin driven low only by internal sources, never by the pin itself
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reset_pin_o <= 1'b1;
      reset_pin_oe_n <= 1'b1;
    end
    else
    begin
      reset_pin_o <= 1'b0;
      reset_pin_oe_n <= !(sp_fault | lv_fault);
    end
  end
  // captured on entry only, so a held reset keeps the first standby level
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ram_retain_q <= 1'b0;
      carrier_retain_q <= 1'b0;
    end
    else if (any_reset && state_q != ST_RESET)
    begin
      ram_retain_q <= standby_i;
      carrier_retain_q <= standby_i;
    end
  end
  // reset-time values; counters run elsewhere, held here only
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      transfer_buffer_word <= `RSIC_DBF_RESET;
      core_system_regs <= `RSIC_CORE_SYSTEM_REGS_RESET;
      port_dir_out_q <= {PORT_W{1'b0}};
      port_latch_q <= {PORT_W{1'b0}};
    end
    else if (core_reset_q)
    begin
      transfer_buffer_word <= `RSIC_DBF_RESET;
      core_system_regs <= `RSIC_CORE_SYSTEM_REGS_RESET;
      port_dir_out_q <= {PORT_W{1'b0}};
      port_latch_q <= {PORT_W{1'b0}};
    end
  end
  // timers clear in standby and operation alike
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer8_count <= `RSIC_TMC_RESET;
      timer8_modulo <= `RSIC_TMM_RESET;
      wdt_count_q <= `RSIC_WDT_RESET;
    end
    else if (core_reset_q)
    begin
      timer8_count <= `RSIC_TMC_RESET;
      timer8_modulo <= `RSIC_TMM_RESET;
      wdt_count_q <= `RSIC_WDT_RESET;
    end
  end
  // free-running divider; only used when the half rate option is built
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      half_q <= 1'b0;
    else
      half_q <= !half_q;
  end
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      carrier_clk_en_q <= 1'b0;
    else if (CARRIER_CLOCK_OPTION == 0)
      carrier_clk_en_q <= 1'b1;
    else
      carrier_clk_en_q <= half_q;
  end
  // direction is a build option, no runtime control exists
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      option_pin_out_q <= 1'b0;
      option_pin_oe_n <= 1'b1;
      option_pin_rd_q <= 1'b0;
    end
    else if (OPTION_PIN_DIRECTION != 0)
    begin
      option_pin_out_q <= option_pin_wdata_i;
      option_pin_oe_n <= core_reset_q;
      option_pin_rd_q <= option_pin_wdata_i;
    end
    else
    begin
      option_pin_out_q <= 1'b0;
      option_pin_oe_n <= 1'b1;
      option_pin_rd_q <= opt_sync;
    end
  end
  // ops outside run are dropped, not queued for after the restart
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regfile_we_q <= 1'b0;
      regfile_wdata_q <= 4'h0;
    end
    else
    begin
      regfile_we_q <= regfile_write_op & run_q;
      regfile_wdata_q <= window_wdata_i;
    end
  end
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      window_rdata_q <= 4'h0;
    else if (regfile_read_op & run_q)
      window_rdata_q <= regfile_rdata_i;
  end
endmodule // rsic_reset_ctrl

// File: rsic_reset_ctrl_bench.sv
module rsic_reset_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, reset_pin_n_i, low_vdd_i, call_i, ret_i, standby_i, regfile_write_op, do_call, do_ret;
  logic reset_pin_oe_n, core_reset_q, run_q, lv_flag_q, ram_retain_q, carrier_retain_q, regfile_we_q;
  logic [2:0] sp_i;
  logic [3:0] window_wdata_i, core_system_regs, port_dir_out_q, port_latch_q, regfile_wdata_q;
  logic [7:0] timer8_count, timer8_modulo, wdt_count_q;
  logic [15:0] transfer_buffer_word;
  logic regfile_read_op;
  logic [3:0] regfile_rdata_i, window_rdata_q;
  int n_errors = 0;
  int tests_run = 0;
  rsic_reset_ctrl #(.LV_CYCLES(8), .WAIT_CYCLES(16)) uut (.clk, .rstn, .reset_pin_n_i, .low_vdd_i, .sp_i,
    .sp_valid_i(1'b1), .call_i, .ret_i, .standby_i, .regfile_read_op, .regfile_write_op, .window_wdata_i,
    .regfile_rdata_i, .option_pin_in_i(1'b0), .option_pin_wdata_i(1'b0), .reset_pin_o(), .reset_pin_oe_n,
    .core_reset_q, .pc_clear_q(), .run_q, .lv_flag_q, .ram_retain_q, .carrier_retain_q, .transfer_buffer_word,
    .core_system_regs, .timer8_count, .timer8_modulo, .wdt_count_q, .port_dir_out_q, .port_latch_q,
    .carrier_clk_en_q(), .option_pin_out_q(), .option_pin_oe_n(), .option_pin_rd_q(), .regfile_we_q,
    .regfile_wdata_q, .window_rdata_q);
  rsic_core_model m (.clk, .run_q, .do_call, .do_ret, .pin_oe_n(reset_pin_oe_n), .pin_n(reset_pin_n_i),
    .sp(sp_i), .call(call_i), .ret(ret_i));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded: a core that never restarts ends the run
  task wait_run(output int n);
    n = 0;
    while (run_q !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200)
    begin
      n_errors++;
      results();
    end
    @(posedge clk);
  endtask
  task t_boot();
    int n;
    chk(transfer_buffer_word, 16'h0320);
    chk({timer8_count, timer8_modulo}, 16'h00ff);
    chk({wdt_count_q, core_system_regs, port_dir_out_q}, 16'h0000);
    chk({port_latch_q, run_q}, 16'h0000);
    rstn <= 1'b1;
    wait_run(n);
    chk(n >= 16, 16'h0001);
    $display("boot done");
  endtask
  task t_under();
    int n;
    standby_i <= 1'b1;
    do_call <= 1'b1;
    repeat (6) @(posedge clk);
    do_call <= 1'b0;
    #1;
    chk({reset_pin_oe_n, core_reset_q, ram_retain_q, carrier_retain_q}, 16'h0007);
    wait_run(n);
    $display("underflow done");
  endtask
  task t_over();
    int n;
    standby_i <= 1'b0;
    do_ret <= 1'b1;
    regfile_write_op <= 1'b1;
    window_wdata_i <= 4'ha;
    regfile_read_op <= 1'b1;
    regfile_rdata_i <= 4'h5;
    @(posedge clk);
    do_ret <= 1'b0;
    regfile_write_op <= 1'b0;
    regfile_read_op <= 1'b0;
    #1;
    chk({regfile_we_q, regfile_wdata_q, window_rdata_q}, 16'h01a5);
    @(posedge clk);
    #1;
    chk({reset_pin_oe_n, core_reset_q, ram_retain_q, carrier_retain_q}, 16'h0004);
    wait_run(n);
    $display("overflow done");
  endtask
  task t_lv();
    int n;
    low_vdd_i <= 1'b1;
    n = 0;
    while (lv_flag_q !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    regfile_write_op <= 1'b1;
    @(posedge clk);
    regfile_write_op <= 1'b0;
    low_vdd_i <= 1'b0;
    #1;
    chk({n <= 12, reset_pin_oe_n, core_reset_q, regfile_we_q}, 16'h000a);
    wait_run(n);
    $display("low supply done");
  endtask
  task t_rearm();
    int n;
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    chk({core_reset_q, run_q, reset_pin_oe_n}, 16'h0005);
    chk(transfer_buffer_word, 16'h0320);
    @(posedge clk);
    rstn <= 1'b1;
    wait_run(n);
    chk(n >= 16, 16'h0001);
    $display("rearm done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {rstn, low_vdd_i, standby_i, regfile_write_op, do_call, do_ret} = 6'h00;
    window_wdata_i = 4'h0;
    regfile_read_op = 1'b0;
    regfile_rdata_i = 4'h0;
    repeat (20) @(posedge clk);
    t_boot();
    t_under();
    t_over();
    t_lv();
    t_rearm();
    results();
  end
endmodule // rsic_reset_ctrl_bench
